// *** hdl/fifo_ctl_pkg.sv ***
package fifo_ctl_pkg;

   // ==========================================================
   // Data path and storage
   localparam int DATA_W = 36;
   localparam int DEPTH = 2048;
   localparam int ADDR_W = 11;
   localparam int PTR_W = 12;
   localparam int OFF_W = 11;

   // ==========================================================
   // Timing counts
   localparam int RESET_EDGES = 4;
   localparam logic [1:0] READY_CYCLES = 2'h2;
   localparam logic [2:0] PULSE_CYCLES = 3'h4;

   // ==========================================================
   // Flag select codes {fs2, fs1, fs0} and preset offsets
   localparam logic [2:0] FS_OFF_64 = 3'h7;
   localparam logic [2:0] FS_OFF_16 = 3'h6;
   localparam logic [2:0] FS_OFF_8 = 3'h5;
   localparam logic [2:0] FS_OFF_256 = 3'h3;
   localparam logic [2:0] FS_OFF_1024 = 3'h1;
   localparam logic [OFF_W-1:0] OFF_64 = 11'h040;
   localparam logic [OFF_W-1:0] OFF_16 = 11'h010;
   localparam logic [OFF_W-1:0] OFF_8 = 11'h008;
   localparam logic [OFF_W-1:0] OFF_256 = 11'h100;
   localparam logic [OFF_W-1:0] OFF_1024 = 11'h400;
   localparam logic [1:0] PARALLEL_WRITES = 2'h2;

   // ==========================================================
   // Controller register map
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [REG_AW-1:0] REG_TX_FIFO = 8'h08;
   localparam logic [REG_AW-1:0] REG_TX_MBX_AB = 8'h0c;
   localparam logic [REG_AW-1:0] REG_TX_MBX_BA = 8'h10;
   localparam logic [REG_AW-1:0] REG_RX_B = 8'h14;
   localparam logic [REG_AW-1:0] REG_RX_A = 8'h18;

   // Control register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_BIG_BIT = 2;
   localparam int CTRL_FT_BIT = 3;
   localparam int CTRL_FS_LSB = 4;
   localparam int CTRL_FETCH_FIFO_BIT = 7;
   localparam int CTRL_FETCH_MBX_AB_BIT = 8;
   localparam int CTRL_FETCH_MBX_BA_BIT = 9;
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_FULL_RESET = 2'h1;
   localparam logic [1:0] OP_PARTIAL = 2'h2;
   localparam logic [1:0] OP_REWIND = 2'h3;

   // ==========================================================
   // State encodings
   typedef enum logic [2:0]
   {
      CFG_RESET = 3'h1,
      CFG_TIMING = 3'h2,
      CFG_RUN = 3'h4
   } cfg_state_type;

   typedef enum logic [2:0]
   {
      H_IDLE = 3'h1,
      H_PULSE = 3'h2,
      H_HOLD = 3'h4
   } host_state_type;

endpackage

// *** hdl/fifo_link_if.sv ***
`timescale 1ns/10ps
interface fifo_link_if;
   import fifo_ctl_pkg::*;
   logic master_reset_n;
   logic second_reset_n;
   logic partial_reset_n;
   logic rewind_mode_select;
   logic endian_select;
   logic flag_select_0;
   logic flag_select_1;
   logic flag_select_2;
   logic a_write;
   logic a_read;
   logic port_a_mailbox_select;
   logic a_out_en;
   logic [DATA_W-1:0] a_wdata;
   logic [DATA_W-1:0] a_rdata;
   logic b_write;
   logic b_read;
   logic port_b_mailbox_select;
   logic b_out_en;
   logic [DATA_W-1:0] b_wdata;
   logic [DATA_W-1:0] b_rdata;
   logic full_or_input_ready;
   logic empty_or_output_ready;
   logic almost_empty_n;
   logic almost_full_n;
   logic mailbox_ab_full_n;
   logic mailbox_ba_full_n;

   modport device
   (
      input master_reset_n, second_reset_n, partial_reset_n, rewind_mode_select, endian_select,
      input flag_select_0, flag_select_1, flag_select_2,
      input a_write, a_read, port_a_mailbox_select, a_out_en, a_wdata,
      input b_write, b_read, port_b_mailbox_select, b_out_en, b_wdata,
      output a_rdata, b_rdata, full_or_input_ready, empty_or_output_ready,
      output almost_empty_n, almost_full_n, mailbox_ab_full_n, mailbox_ba_full_n
   );

   modport controller
   (
      output master_reset_n, second_reset_n, partial_reset_n, rewind_mode_select, endian_select,
      output flag_select_0, flag_select_1, flag_select_2,
      output a_write, a_read, port_a_mailbox_select, a_out_en, a_wdata,
      output b_write, b_read, port_b_mailbox_select, b_out_en, b_wdata,
      input a_rdata, b_rdata, full_or_input_ready, empty_or_output_ready,
      input almost_empty_n, almost_full_n, mailbox_ab_full_n, mailbox_ba_full_n
   );
endinterface

// *** hdl/fifo_device_end.sv ***
`timescale 1ns/10ps
module fifo_device_end
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_clk_en,
   fifo_link_if.device link,
   output logic o_big_endian,
   output logic o_fall_through,
   output logic [fifo_ctl_pkg::OFF_W-1:0] o_almost_empty_offset,
   output logic [fifo_ctl_pkg::OFF_W-1:0] o_almost_full_offset,
   output logic o_offset_load_pending
);
   import fifo_ctl_pkg::*;

   typedef struct packed
   {
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [1:0] ready_cnt;
      logic head_valid;
      logic [DATA_W-1:0] b_word;
   } core_type;

   typedef struct packed
   {
      cfg_state_type state;
      logic big_endian;
      logic fall_through;
      logic [2:0] fsel;
      logic [1:0] prog_left;
      logic [OFF_W-1:0] empty_off;
      logic [OFF_W-1:0] full_off;
   } cfg_type;

   typedef struct packed
   {
      logic full;
      logic [DATA_W-1:0] word;
   } mbx_type;

   core_type core;
   core_type next_core;
   cfg_type cfg;
   cfg_type next_cfg;
   mbx_type mbx_ab;
   mbx_type next_mbx_ab;
   mbx_type mbx_ba;
   mbx_type next_mbx_ba;
   logic [DATA_W-1:0] mem [DEPTH];

   logic partial_active;
   logic rewind_active;
   logic core_rst_n;
   logic ab_rst_n;
   logic ba_rst_n;
   logic [PTR_W-1:0] count;
   logic [PTR_W-1:0] space;
   logic in_ready;
   logic a_take;
   logic prog_write;
   logic fifo_write;
   logic b_pop;

   function automatic logic [OFF_W-1:0] preset_offset(input logic [2:0] fs);
      logic [OFF_W-1:0] off;
      off = OFF_64;
      case (fs)
         FS_OFF_16: off = OFF_16;
         FS_OFF_8: off = OFF_8;
         FS_OFF_256: off = OFF_256;
         FS_OFF_1024: off = OFF_1024;
         default: off = OFF_64;
      endcase
      return off;
   endfunction

   // ==========================================================
   // Reset steering
   assign partial_active = ~link.partial_reset_n & ~link.rewind_mode_select;
   assign rewind_active = ~link.partial_reset_n & link.rewind_mode_select;
   assign core_rst_n = i_arst_n & link.master_reset_n & ~partial_active;
   assign ab_rst_n = i_arst_n & link.master_reset_n & ~partial_active;
   assign ba_rst_n = i_arst_n & link.second_reset_n & ~partial_active;

   // ==========================================================
   // Occupancy and flags
   assign count = core.wptr - core.rptr;
   assign space = PTR_W'(DEPTH) - count;
   assign in_ready = (core.ready_cnt == READY_CYCLES) && (count != PTR_W'(DEPTH)) && (cfg.state == CFG_RUN);
   assign a_take = link.a_write & ~link.port_a_mailbox_select & in_ready;
   assign prog_write = a_take & (cfg.prog_left != 2'h0);
   assign fifo_write = a_take & (cfg.prog_left == 2'h0);

   // Ready must rise even while offsets are still awaited, or parallel loading could never start
   assign link.full_or_input_ready = in_ready;
   assign link.empty_or_output_ready = cfg.fall_through ? core.head_valid : (count != '0);
   assign link.almost_empty_n = count > PTR_W'(cfg.empty_off);
   assign link.almost_full_n = space > PTR_W'(cfg.full_off);
   assign link.mailbox_ab_full_n = ~mbx_ab.full;
   assign link.mailbox_ba_full_n = ~mbx_ba.full;

   // ==========================================================
   // Output buses, zero while not enabled
   assign link.b_rdata = !link.b_out_en ? '0 : link.port_b_mailbox_select ? mbx_ab.word : core.b_word;
   assign link.a_rdata = (link.a_out_en & link.port_a_mailbox_select) ? mbx_ba.word : '0;

   assign o_big_endian = cfg.big_endian;
   assign o_fall_through = cfg.fall_through;
   assign o_almost_empty_offset = cfg.empty_off;
   assign o_almost_full_offset = cfg.full_off;
   assign o_offset_load_pending = cfg.prog_left != 2'h0;

   // ==========================================================
   // FIFO pointers and read word
   always_comb
   begin
      next_core = core;
      b_pop = 1'b0;
      if (core.ready_cnt != READY_CYCLES)
      begin
         next_core.ready_cnt = core.ready_cnt + 2'h1;
      end
      if (fifo_write)
      begin
         next_core.wptr = core.wptr + PTR_W'(1);
      end
      if (cfg.fall_through)
      begin
         if ((!core.head_valid || (link.b_read && !link.port_b_mailbox_select)) && count != '0)
         begin
            b_pop = 1'b1;
            next_core.head_valid = 1'b1;
         end
         else if (link.b_read && !link.port_b_mailbox_select)
         begin
            next_core.head_valid = 1'b0;
         end
      end
      else if (link.b_read && !link.port_b_mailbox_select && count != '0)
      begin
         b_pop = 1'b1;
      end
      if (b_pop)
      begin
         next_core.b_word = mem[core.rptr[ADDR_W-1:0]];
         next_core.rptr = core.rptr + PTR_W'(1);
      end
      if (rewind_active)
      begin
         next_core.rptr = '0;
         next_core.head_valid = 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         core <= '0;
      end
      else if (i_clk_en)
      begin
         core <= next_core;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_clk_en && fifo_write)
      begin
         mem[core.wptr[ADDR_W-1:0]] <= link.a_wdata;
      end
   end

   // ==========================================================
   // Configuration, untouched by partial reset
   always_comb
   begin
      next_cfg = cfg;
      case (cfg.state)
         CFG_RESET:
         begin
            if (link.master_reset_n)
            begin
               next_cfg.big_endian = link.endian_select;
               next_cfg.fsel = {link.flag_select_2, link.flag_select_1, link.flag_select_0};
               next_cfg.empty_off = preset_offset(next_cfg.fsel);
               next_cfg.full_off = preset_offset(next_cfg.fsel);
               next_cfg.prog_left = (!link.flag_select_1 && !link.flag_select_0) ? PARALLEL_WRITES : 2'h0;
               next_cfg.state = CFG_TIMING;
            end
         end
         CFG_TIMING:
         begin
            next_cfg.fall_through = ~link.endian_select;
            next_cfg.state = CFG_RUN;
         end
         CFG_RUN:
         begin
            if (prog_write)
            begin
               if (cfg.prog_left == PARALLEL_WRITES)
               begin
                  next_cfg.full_off = link.a_wdata[OFF_W-1:0];
               end
               else
               begin
                  next_cfg.empty_off = link.a_wdata[OFF_W-1:0];
               end
               next_cfg.prog_left = cfg.prog_left - 2'h1;
            end
         end
         default:
         begin
            next_cfg.state = CFG_RESET;
         end
      endcase
      if (!link.master_reset_n)
      begin
         next_cfg.state = CFG_RESET;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cfg <= '{state: CFG_RESET, big_endian: 1'b0, fall_through: 1'b0, fsel: FS_OFF_64,
                  prog_left: 2'h0, empty_off: OFF_64, full_off: OFF_64};
      end
      else if (i_clk_en)
      begin
         cfg <= next_cfg;
      end
   end

   // ==========================================================
   // Mailboxes: a write is taken only while empty, so a read of a full mailbox wins over a write in the same cycle
   always_comb
   begin
      next_mbx_ab = mbx_ab;
      next_mbx_ba = mbx_ba;
      if (link.b_read && link.port_b_mailbox_select)
      begin
         next_mbx_ab.full = 1'b0;
      end
      if (link.a_write && link.port_a_mailbox_select && !mbx_ab.full)
      begin
         next_mbx_ab = '{full: 1'b1, word: link.a_wdata};
      end
      if (link.a_read && link.port_a_mailbox_select)
      begin
         next_mbx_ba.full = 1'b0;
      end
      if (link.b_write && link.port_b_mailbox_select && !mbx_ba.full)
      begin
         next_mbx_ba = '{full: 1'b1, word: link.b_wdata};
      end
   end

   always_ff @(posedge i_mclk or negedge ab_rst_n)
   begin
      if (!ab_rst_n)
      begin
         mbx_ab <= '0;
      end
      else if (i_clk_en)
      begin
         mbx_ab <= next_mbx_ab;
      end
   end

   always_ff @(posedge i_mclk or negedge ba_rst_n)
   begin
      if (!ba_rst_n)
      begin
         mbx_ba <= '0;
      end
      else if (i_clk_en)
      begin
         mbx_ba <= next_mbx_ba;
      end
   end

endmodule

// *** hdl/fifo_controller_end.sv ***
`timescale 1ns/10ps
module fifo_controller_end
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_clk_en,
   input wire logic [fifo_ctl_pkg::REG_AW-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic [fifo_ctl_pkg::DATA_W-1:0] o_rx_b_word,
   output logic [fifo_ctl_pkg::DATA_W-1:0] o_rx_a_word,
   fifo_link_if.controller link
);
   import fifo_ctl_pkg::*;

   typedef struct packed
   {
      host_state_type state;
      logic [1:0] op;
      logic [2:0] cnt;
      logic big;
      logic ft;
      logic [2:0] fsel;
      logic mrst_n;
      logic prst_n;
      logic mode;
      logic a_write;
      logic a_read;
      logic a_mbx_sel;
      logic [DATA_W-1:0] a_wdata;
      logic b_write;
      logic b_read;
      logic b_mbx_sel;
      logic [DATA_W-1:0] b_wdata;
      logic cap_b;
      logic cap_a;
      logic [DATA_W-1:0] rx_b;
      logic [DATA_W-1:0] rx_a;
      logic [31:0] rdata;
   } host_type;

   host_type h;
   host_type next_h;

   assign link.master_reset_n = h.mrst_n;
   assign link.second_reset_n = h.mrst_n;
   assign link.partial_reset_n = h.prst_n;
   assign link.rewind_mode_select = h.mode;
   assign link.endian_select = (h.state == H_IDLE) ? ~h.ft : h.big;
   assign link.flag_select_0 = h.fsel[0];
   assign link.flag_select_1 = h.fsel[1];
   assign link.flag_select_2 = h.fsel[2];
   assign link.a_write = h.a_write;
   assign link.a_read = h.a_read;
   assign link.port_a_mailbox_select = h.a_mbx_sel;
   assign link.a_out_en = 1'b1;
   assign link.a_wdata = h.a_wdata;
   assign link.b_write = h.b_write;
   assign link.b_read = h.b_read;
   assign link.port_b_mailbox_select = h.b_mbx_sel;
   assign link.b_out_en = 1'b1;
   assign link.b_wdata = h.b_wdata;
   assign o_rdata = h.rdata;
   assign o_rx_b_word = h.rx_b;
   assign o_rx_a_word = h.rx_a;

   // ==========================================================
   // Register port, pulse sequencer and port strobes
   always_comb
   begin
      next_h = h;
      next_h.a_write = 1'b0;
      next_h.a_read = 1'b0;
      // A mailbox word shows only while its select is high: keep it through the capture cycle
      next_h.a_mbx_sel = h.a_read & h.a_mbx_sel;
      next_h.b_write = 1'b0;
      next_h.b_read = 1'b0;
      next_h.b_mbx_sel = h.b_read & h.b_mbx_sel;
      next_h.cap_b = h.b_read;
      next_h.cap_a = h.a_read;
      next_h.rdata = '0;
      if (h.cap_b)
      begin
         next_h.rx_b = link.b_rdata;
      end
      if (h.cap_a)
      begin
         next_h.rx_a = link.a_rdata;
      end
      case (h.state)
         H_IDLE:
         begin
            if (i_wr && i_addr == REG_CTRL && i_wdata[CTRL_OP_LSB +: 2] != OP_NONE)
            begin
               next_h.op = i_wdata[CTRL_OP_LSB +: 2];
               next_h.big = i_wdata[CTRL_BIG_BIT];
               next_h.ft = i_wdata[CTRL_FT_BIT];
               next_h.fsel = i_wdata[CTRL_FS_LSB +: 3];
               next_h.cnt = 3'h0;
               next_h.mode = (i_wdata[CTRL_OP_LSB +: 2] == OP_REWIND);
               next_h.state = H_PULSE;
            end
         end
         H_PULSE:
         begin
            next_h.mrst_n = (h.op != OP_FULL_RESET);
            next_h.prst_n = (h.op == OP_FULL_RESET);
            next_h.cnt = h.cnt + 3'h1;
            if (h.cnt == PULSE_CYCLES)
            begin
               next_h.mrst_n = 1'b1;
               next_h.prst_n = 1'b1;
               next_h.state = H_HOLD;
            end
         end
         H_HOLD:
         begin
            next_h.state = H_IDLE;
         end
         default:
         begin
            next_h.state = H_IDLE;
         end
      endcase
      if (h.state == H_IDLE && i_wr)
      begin
         if (i_addr == REG_TX_FIFO || i_addr == REG_TX_MBX_AB)
         begin
            next_h.a_write = 1'b1;
            next_h.a_mbx_sel = (i_addr == REG_TX_MBX_AB);
            next_h.a_wdata = DATA_W'(i_wdata);
         end
         else if (i_addr == REG_TX_MBX_BA)
         begin
            next_h.b_write = 1'b1;
            next_h.b_mbx_sel = 1'b1;
            next_h.b_wdata = DATA_W'(i_wdata);
         end
         else if (i_addr == REG_CTRL)
         begin
            next_h.b_read = i_wdata[CTRL_FETCH_FIFO_BIT] | i_wdata[CTRL_FETCH_MBX_AB_BIT];
            next_h.b_mbx_sel = i_wdata[CTRL_FETCH_MBX_AB_BIT];
            next_h.a_read = i_wdata[CTRL_FETCH_MBX_BA_BIT];
            next_h.a_mbx_sel = i_wdata[CTRL_FETCH_MBX_BA_BIT];
         end
      end
      if (i_rd)
      begin
         case (i_addr)
            REG_CTRL: next_h.rdata = {22'h0, 3'h0, h.fsel, h.ft, h.big, h.op};
            REG_STATUS: next_h.rdata = {25'h0, h.state != H_IDLE, link.mailbox_ba_full_n, link.mailbox_ab_full_n,
                                        link.almost_full_n, link.almost_empty_n, link.empty_or_output_ready,
                                        link.full_or_input_ready};
            REG_RX_B: next_h.rdata = h.rx_b[31:0];
            REG_RX_A: next_h.rdata = h.rx_a[31:0];
            default: next_h.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         h <= '{state: H_IDLE, op: OP_NONE, cnt: 3'h0, big: 1'b0, ft: 1'b0, fsel: FS_OFF_64, mrst_n: 1'b1,
                prst_n: 1'b1, mode: 1'b0, a_write: 1'b0, a_read: 1'b0, a_mbx_sel: 1'b0, a_wdata: '0,
                b_write: 1'b0, b_read: 1'b0, b_mbx_sel: 1'b0, b_wdata: '0, cap_b: 1'b0, cap_a: 1'b0, rx_b: '0, rx_a: '0,
                rdata: '0};
      end
      else if (i_clk_en)
      begin
         h <= next_h;
      end
   end

endmodule

// *** testbench/fifo_link_props.sv ***
`timescale 1ns/10ps
module fifo_link_props
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic master_reset_n,
   input wire logic second_reset_n,
   input wire logic partial_reset_n,
   input wire logic rewind_mode_select,
   input wire logic a_write,
   input wire logic port_a_mailbox_select,
   input wire logic a_out_en,
   input wire logic [fifo_ctl_pkg::DATA_W-1:0] a_wdata,
   input wire logic [fifo_ctl_pkg::DATA_W-1:0] a_rdata,
   input wire logic b_write,
   input wire logic port_b_mailbox_select,
   input wire logic b_out_en,
   input wire logic [fifo_ctl_pkg::DATA_W-1:0] b_wdata,
   input wire logic [fifo_ctl_pkg::DATA_W-1:0] b_rdata,
   input wire logic full_or_input_ready,
   input wire logic empty_or_output_ready,
   input wire logic almost_empty_n,
   input wire logic almost_full_n,
   input wire logic mailbox_ab_full_n,
   input wire logic mailbox_ba_full_n
);
   import fifo_ctl_pkg::*;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);

   // ==========================================================
   // Reset and partial reset
   reset_flags_a: assert property (!master_reset_n |-> !full_or_input_ready &&
      !empty_or_output_ready && !almost_empty_n && almost_full_n) else $error("flags wrong in reset");
   mbx_ab_force_a: assert property (!master_reset_n |-> mailbox_ab_full_n)
      else $error("mailbox ab flag not forced");
   mbx_ba_force_a: assert property (!second_reset_n |-> mailbox_ba_full_n)
      else $error("mailbox ba flag not forced");
   partial_clear_a: assert property (!partial_reset_n && !rewind_mode_select |->
      !full_or_input_ready && !empty_or_output_ready && !almost_empty_n && almost_full_n &&
      mailbox_ab_full_n && mailbox_ba_full_n) else $error("flags wrong in partial reset");
   ready_delay_a: assert property ($rose(master_reset_n) ||
      ($rose(partial_reset_n) && !rewind_mode_select && master_reset_n) |->
      !full_or_input_ready ##1 !full_or_input_ready ##1 full_or_input_ready) else $error("ready late or early");

   // ==========================================================
   // Rewind and mailboxes
   rewind_keep_a: assert property (!partial_reset_n && rewind_mode_select && master_reset_n |=>
      $stable(mailbox_ab_full_n) && $stable(mailbox_ba_full_n)) else $error("rewind touched mailbox");
   mbx_ab_pass_a: assert property (a_write && port_a_mailbox_select && mailbox_ab_full_n &&
      master_reset_n && partial_reset_n |=> !mailbox_ab_full_n &&
      (!(b_out_en && port_b_mailbox_select) || b_rdata == $past(a_wdata))) else $error("mailbox ab lost");
   mbx_ba_pass_a: assert property (b_write && port_b_mailbox_select && mailbox_ba_full_n &&
      second_reset_n && partial_reset_n |=> !mailbox_ba_full_n &&
      (!(a_out_en && port_a_mailbox_select) || a_rdata == $past(b_wdata))) else $error("mailbox ba lost");
endmodule

// *** testbench/test_fifo_reset_retransmit_control.sv ***
`timescale 1ns/10ps
module test_fifo_reset_retransmit_control;
   import fifo_ctl_pkg::*;
   // Big endian, standard timing, preset 8 / little endian, fall-through, parallel load
   localparam logic [31:0] CFG_A = 32'h54;
   localparam logic [31:0] CFG_B = 32'h48;
   localparam logic [31:0] GET_B = 32'h1 << CTRL_FETCH_FIFO_BIT;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [REG_AW-1:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [DATA_W-1:0] rx_b;
   logic [DATA_W-1:0] rx_a;
   logic big_endian;
   logic fall_through;
   logic [OFF_W-1:0] empty_offset;
   logic [OFF_W-1:0] full_offset;
   logic load_pending;
   logic [31:0] seen;
   int fail_count = 0;
   int tests_run = 0;

   always #5 mclk = ~mclk;

   fifo_link_if link ();
   fifo_device_end fifo_device_end_inst (.i_mclk(mclk), .i_arst_n(arst_n), .i_clk_en(1'b1), .link(link.device),
      .o_big_endian(big_endian), .o_fall_through(fall_through), .o_almost_empty_offset(empty_offset),
      .o_almost_full_offset(full_offset), .o_offset_load_pending(load_pending));
   fifo_controller_end fifo_controller_end_inst (.i_mclk(mclk), .i_arst_n(arst_n), .i_clk_en(1'b1),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rx_b_word(rx_b),
      .o_rx_a_word(rx_a), .link(link.controller));
   fifo_link_props fifo_link_props_inst (.i_mclk(mclk), .i_arst_n(arst_n), .master_reset_n(link.master_reset_n),
      .second_reset_n(link.second_reset_n), .partial_reset_n(link.partial_reset_n),
      .rewind_mode_select(link.rewind_mode_select), .a_write(link.a_write), .a_out_en(link.a_out_en),
      .port_a_mailbox_select(link.port_a_mailbox_select), .a_wdata(link.a_wdata), .a_rdata(link.a_rdata),
      .b_write(link.b_write), .port_b_mailbox_select(link.port_b_mailbox_select), .b_out_en(link.b_out_en),
      .b_wdata(link.b_wdata), .b_rdata(link.b_rdata), .full_or_input_ready(link.full_or_input_ready),
      .empty_or_output_ready(link.empty_or_output_ready), .almost_empty_n(link.almost_empty_n),
      .almost_full_n(link.almost_full_n), .mailbox_ab_full_n(link.mailbox_ab_full_n),
      .mailbox_ba_full_n(link.mailbox_ba_full_n));

   // ==========================================================
   // Bus tasks and comparison
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge mclk);
   endtask

   // Write, then poll until the sequencer is idle again
   task automatic put(input logic [REG_AW-1:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
      for (int n = 0; n < 40; n++)
      begin
         reg_rd(REG_STATUS, seen);
         if (seen[6] === 1'b0)
         begin
            repeat (4) @(posedge mclk);
            return;
         end
      end
      fail_count++;
      $display("[ERR] %0t sequencer stuck busy", $time);
      complete_run();
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      put(REG_CTRL, CFG_A | OP_FULL_RESET);
      check(big_endian, 1'b1);
      check({full_offset, empty_offset}, {OFF_8, OFF_8});
      check(fall_through, 1'b0);
      reg_rd(REG_STATUS, seen);
      check(seen, 32'h39);
      for (int i = 1; i < 4; i++)
      begin
         put(REG_TX_FIFO, 32'h11 * i);
      end
      put(REG_CTRL, CFG_A | GET_B);
      check(rx_b, 36'h11);
      put(REG_CTRL, CFG_A | OP_REWIND);
      for (int i = 1; i < 4; i++)
      begin
         put(REG_CTRL, CFG_A | GET_B);
         check(rx_b, 36'h11 * i);
      end
      reg_rd(REG_STATUS, seen);
      check(seen[1], 1'b0);
      reg_rd(REG_RX_B, seen);
      check(seen, 32'h33);
      put(REG_TX_MBX_AB, 32'ha5);
      reg_rd(REG_STATUS, seen);
      check(seen[5:4], 2'h2);
      put(REG_CTRL, CFG_A | (32'h1 << CTRL_FETCH_MBX_AB_BIT));
      check(rx_b, 36'ha5);
      put(REG_TX_MBX_BA, 32'h5a);
      put(REG_CTRL, CFG_A | (32'h1 << CTRL_FETCH_MBX_BA_BIT));
      check(rx_a, 36'h5a);
      reg_rd(REG_RX_A, seen);
      check(seen, 32'h5a);
      reg_rd(8'hfc, seen);
      check(seen, 32'h0);
      put(REG_TX_FIFO, 32'h44);
      put(REG_TX_MBX_AB, 32'h77);
      put(REG_TX_MBX_BA, 32'h66);
      // Other strap levels during a partial reset must not be taken up
      put(REG_CTRL, CFG_B | OP_PARTIAL);
      reg_rd(REG_STATUS, seen);
      check(seen, 32'h39);
      check({big_endian, fall_through, empty_offset}, {2'h2, OFF_8});
      put(REG_CTRL, CFG_B | OP_FULL_RESET);
      check({big_endian, fall_through, load_pending}, 3'h3);
      put(REG_TX_FIFO, 32'h3);
      put(REG_TX_FIFO, 32'h5);
      check({full_offset, empty_offset, load_pending}, {11'h003, 11'h005, 1'b0});
      reg_rd(REG_STATUS, seen);
      check(seen[1:0], 2'h1);
      put(REG_TX_FIFO, 32'h99);
      reg_rd(REG_STATUS, seen);
      check(seen[1], 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         put(REG_TX_FIFO, 32'h20 + i);
      end
      reg_rd(REG_STATUS, seen);
      check(seen[2], 1'b1);
      put(REG_CTRL, CFG_B | OP_PARTIAL);
      check({full_offset, empty_offset, fall_through}, {11'h003, 11'h005, 1'b1});
      reg_rd(REG_STATUS, seen);
      check(seen[3:0], 4'h9);
      complete_run();
   end
endmodule
